// ==== rci_defs.svh ====
/*
 * constants of the remote command interpreter: buffer size, token size,
 * setting memory count, status bit positions and error numbers.
 * assumes inclusion by the package and by the top module only.
 */
`ifndef RCI_DEFS_SVH
`define RCI_DEFS_SVH

// -----------------------------------------------------------------
// sizes
// -----------------------------------------------------------------
`define RCI_BUF_DEPTH 10000
`define RCI_TOK_CHARS 10
`define RCI_SLOTS 20
`define RCI_RESP_CHARS 16

// -----------------------------------------------------------------
// status bit positions
// -----------------------------------------------------------------
`define RCI_ESR_OPC 0
`define RCI_ESR_EXE 4
`define RCI_ESR_CME 5
`define RCI_STB_EAV 2
`define RCI_STB_MAV 4
`define RCI_STB_ESB 5
`define RCI_STB_MSS 6
`define RCI_MASK_RESET 8'h00

// -----------------------------------------------------------------
// error numbers, reported with a minus sign
// -----------------------------------------------------------------
`define RCI_ERR_CMD 8'h64
`define RCI_ERR_HDR 8'h71
`define RCI_ERR_RANGE 8'hde

// -----------------------------------------------------------------
// characters
// -----------------------------------------------------------------
`define RCI_CH_LF 8'h0a
`define RCI_CH_SP 8'h20
`define RCI_CH_STAR 8'h2a
`define RCI_CH_COLON 8'h3a
`define RCI_CH_SEMI 8'h3b
`define RCI_CH_QUERY 8'h3f
`define RCI_CH_MINUS 8'h2d
`define RCI_CH_ZERO 8'h30

`endif

// ==== rci_pkg.sv ====
/*
 * types of the remote command interpreter.
 * assumes rci_defs.svh is reachable on the include path.
 */
`include "rci_defs.svh"

package rci_pkg;

	// -------------------------------------------------------------
	// header keywords, then common commands, then none
	// -------------------------------------------------------------
	typedef enum logic [5:0] {
		KW_SOURCE, KW_FREQUENCY, KW_VOLTAGE, KW_LEVEL, KW_IMMEDIATE,
		KW_AMPLITUDE, KW_UNIT, KW_OFFSET, KW_HIGH, KW_LOW, KW_FUNCTION,
		KW_SHAPE, KW_RAMP, KW_SYMMETRY, KW_PULSE, KW_DCYCLE, KW_USER,
		KW_TRACE, KW_DATA, KW_MODE, KW_BURST, KW_NCYCLES, KW_SPACES,
		KW_PHASE, KW_OUTPUT, KW_SYNC, KW_TYPE, KW_TRIGGER, KW_SEQUENCE,
		KW_SLOPE, KW_GATE, KW_POLARITY, KW_STATE, KW_MEMORY, KW_DELETE,
		KW_SYSTEM, KW_PON, KW_IMPEDANCE, KW_ERROR, KW_CW, KW_FIXED,
		KW_CLS, KW_ESE, KW_ESR, KW_IDN, KW_OPC, KW_RST, KW_SRE, KW_STB,
		KW_TRG, KW_TST, KW_WAI, KW_RCL, KW_NONE
	} rci_kw_t;

	// long and short spelling, right aligned, upper case
	typedef struct packed {
		logic [`RCI_TOK_CHARS*8-1:0] lng;
		logic [`RCI_TOK_CHARS*8-1:0] sht;
	} rci_kwent_t;

	// one decoded device command for the settings engine
	typedef struct packed {
		rci_kw_t path;
		rci_kw_t leaf;
		logic query;
		logic [15:0] value;
	} rci_cmd_t;

	typedef enum logic [2:0] {
		S_LOAD, S_READ, S_CHAR, S_EXEC, S_SEND, S_CLEAR
	} rci_state_t;

endpackage

// ==== rci_buf.sv ====
/*
 * input text buffer: one write port, one read port, registered read.
 * assumes a single clock; contents need no reset.
 */
`timescale 1ns/1ps

module rci_buf
#(
	parameter int W = 8,
	parameter int D = 16,
	parameter int AW = $clog2(D)
)
(
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] wa,
	input wire logic [W-1:0] wd,
	input wire logic [AW-1:0] ra,
	output logic [W-1:0] rd
);

	logic [W-1:0] mem [D];

	// the address must reach every entry
	if (AW < $clog2(D))
		$error("rci_buf: address too narrow for depth");

	// -------------------------------------------------------------
	// storage
	// -------------------------------------------------------------
	// write and registered read
	always_ff @(posedge clk)
	begin
		if (we)
			mem[wa] <= wd;
		rd <= mem[ra];
	end

endmodule

// ==== rci_top.sv ====
/*
 * remote command interpreter: buffers a batch of command text, parses
 * and executes it, keeps event status, masks and the error record.
 * assumes the link logic on MCLK delivers bytes on RX and drains TX,
 * and that a settings engine acts on the command and pulse outputs.
 */
`timescale 1ns/1ps
`include "rci_defs.svh"

module rci_top
	import rci_pkg::*;
#(
	parameter int DEPTH = `RCI_BUF_DEPTH,
	parameter int SLOTS = `RCI_SLOTS,
	// identification text, value arbitrary
	parameter logic [119:0] IDN_STR = "MAKER,FGEN,0,01"
)
(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [7:0] RX_DATA,
	input wire logic RX_VALID,
	output logic RX_READY,
	output logic [7:0] TX_DATA,
	output logic TX_VALID,
	input wire logic TX_READY,
	output rci_cmd_t CMD,
	output logic CMD_VALID,
	output logic TRIG_PULSE,
	output logic INIT_PULSE,
	output logic RECALL_PULSE,
	output logic [4:0] RECALL_SLOT,
	output logic ERR_PULSE,
	output logic [7:0] ERR_CODE,
	output logic [7:0] STATUS_BYTE,
	output logic [7:0] EVENT_STATUS
);

	localparam int CW = $clog2(DEPTH + 1);
	localparam int AW = $clog2(DEPTH);
	localparam int TB = `RCI_TOK_CHARS * 8;
	localparam int KN = 53;
	localparam int RB = `RCI_RESP_CHARS * 8;

	if (DEPTH < 2 || SLOTS < 1 || SLOTS > 31)
		$error("rci_top: DEPTH or SLOTS out of range");

	// -------------------------------------------------------------
	// keyword table
	// -------------------------------------------------------------
	localparam rci_kwent_t KW_TAB [KN] = '{
		'{"SOURCE", "SOUR"}, '{"FREQUENCY", "FREQ"},
		'{"VOLTAGE", "VOLT"}, '{"LEVEL", "LEV"},
		'{"IMMEDIATE", "IMM"}, '{"AMPLITUDE", "AMPL"},
		'{"UNIT", "UNIT"}, '{"OFFSET", "OFFS"}, '{"HIGH", "HIGH"},
		'{"LOW", "LOW"}, '{"FUNCTION", "FUNC"}, '{"SHAPE", "SHAP"},
		'{"RAMP", "RAMP"}, '{"SYMMETRY", "SYMM"}, '{"PULSE", "PULS"},
		'{"DCYCLE", "DCYC"}, '{"USER", "USER"}, '{"TRACE", "TRAC"},
		'{"DATA", "DATA"}, '{"MODE", "MODE"}, '{"BURST", "BURS"},
		'{"NCYCLES", "NCYC"}, '{"SPACES", "SPAC"}, '{"PHASE", "PHAS"},
		'{"OUTPUT", "OUTP"}, '{"SYNC", "SYNC"}, '{"TYPE", "TYPE"},
		'{"TRIGGER", "TRIG"}, '{"SEQUENCE", "SEQ"}, '{"SLOPE", "SLOP"},
		'{"GATE", "GATE"}, '{"POLARITY", "POL"}, '{"STATE", "STAT"},
		'{"MEMORY", "MEM"}, '{"DELETE", "DEL"}, '{"SYSTEM", "SYST"},
		'{"PON", "PON"}, '{"IMPEDANCE", "IMP"}, '{"ERROR", "ERR"},
		'{"CW", "CW"}, '{"FIXED", "FIX"}, '{"CLS", "CLS"},
		'{"ESE", "ESE"}, '{"ESR", "ESR"}, '{"IDN", "IDN"},
		'{"OPC", "OPC"}, '{"RST", "RST"}, '{"SRE", "SRE"},
		'{"STB", "STB"}, '{"TRG", "TRG"}, '{"TST", "TST"},
		'{"WAI", "WAI"}, '{"RCL", "RCL"}
	};

	rci_state_t state_q;
	logic [CW-1:0] wr_q, rd_q;
	logic [TB-1:0] tok_q;
	logic [3:0] tok_n_q;
	logic star_q, hdr_q, qry_q, first_q, last_q, has_val_q;
	logic [15:0] val_q;
	rci_kw_t path_q, leaf_q;
	logic [7:0] esr_q, ese_q, sre_q, err_q;
	logic [RB-1:0] resp_q;
	logic [4:0] resp_n_q;
	logic [7:0] buf_rd;

	// -------------------------------------------------------------
	// input buffer
	// -------------------------------------------------------------
	wire rx_take = RX_VALID && RX_READY;
	assign RX_READY = (state_q == S_LOAD) && (wr_q < CW'(DEPTH));

	rci_buf #(.W(8), .D(DEPTH), .AW(AW)) u_buf (
		.clk(MCLK),
		.we(rx_take),
		.wa(wr_q[AW-1:0]),
		.wd(RX_DATA),
		.ra(rd_q[AW-1:0]),
		.rd(buf_rd)
	);

	// -------------------------------------------------------------
	// character classes
	// -------------------------------------------------------------
	// a read past the stored text acts as an end of line
	wire past_end = (rd_q == wr_q);
	wire [7:0] ch = past_end ? `RCI_CH_LF : buf_rd;
	wire is_lower = (ch >= 8'h61) && (ch <= 8'h7a);
	wire [7:0] ch_up = is_lower ? (ch - 8'h20) : ch;
	wire is_alpha = (ch_up >= 8'h41) && (ch_up <= 8'h5a);
	wire is_digit = (ch >= `RCI_CH_ZERO) && (ch <= 8'h39);
	wire is_lf = (ch == `RCI_CH_LF);
	wire is_term = is_lf || (ch == `RCI_CH_SEMI);
	wire is_hend = is_term || (ch == `RCI_CH_SP) || (ch == `RCI_CH_QUERY);
	wire [19:0] val_mul = {4'h0, val_q} * 20'h0000a + {12'h000, ch - 8'h30};
	wire [15:0] val_nx = (val_mul > 20'h0ffff) ? 16'hffff : val_mul[15:0];

	// -------------------------------------------------------------
	// keyword lookup
	// -------------------------------------------------------------
	logic [KN-1:0] kw_hits;
	rci_kw_t kw_id;
	for (genvar i = 0; i < KN; i++)
	begin : g_kw
		// only exact full or short form
		assign kw_hits[i] = (tok_q == KW_TAB[i].lng)
			|| (tok_q == KW_TAB[i].sht);
	end

	// lowest matching entry
	always_comb
	begin
		kw_id = KW_NONE;
		for (int j = KN - 1; j >= 0; j--)
			if (kw_hits[j])
				kw_id = rci_kw_t'(j);
	end

	// a common name only after a star, a keyword only without
	wire kw_ok = (kw_id != KW_NONE)
		&& (star_q ? (kw_id >= KW_CLS) : (kw_id < KW_CLS));

	// -------------------------------------------------------------
	// character step decode
	// -------------------------------------------------------------
	logic pe_err;
	logic [7:0] pe_code;
	always_comb
	begin
		pe_err = 1'b0;
		pe_code = `RCI_ERR_HDR;
		if (!hdr_q)
		begin
			if (is_alpha)
				pe_err = (tok_n_q == 4'(`RCI_TOK_CHARS));
			else if (ch == `RCI_CH_STAR)
				pe_err = star_q || !first_q || (tok_n_q != 4'h0);
			else if (ch == `RCI_CH_COLON)
				pe_err = star_q || (tok_n_q == 4'h0 ? !first_q : !kw_ok);
			else if (is_hend)
				pe_err = (tok_n_q == 4'h0) ? !(first_q && !star_q
					&& ch != `RCI_CH_QUERY) : !kw_ok;
			else
				pe_err = 1'b1;
		end
	end

	// -------------------------------------------------------------
	// command execution decode
	// -------------------------------------------------------------
	logic ex_err, num_go, num_neg, idn_go, trig_go, init_go, rcl_go;
	logic dev_go;
	logic [7:0] ex_code, num_v;
	wire [7:0] stb_now;
	wire val_big = (val_q > 16'h00ff) || !has_val_q;
	always_comb
	begin
		ex_err = 1'b0;
		ex_code = `RCI_ERR_CMD;
		num_go = 1'b0;
		num_neg = 1'b0;
		num_v = 8'h00;
		idn_go = 1'b0;
		trig_go = 1'b0;
		init_go = 1'b0;
		rcl_go = 1'b0;
		dev_go = 1'b0;
		unique case (leaf_q)
			KW_CLS: ex_err = qry_q;
			KW_ESE, KW_SRE:
			begin
				num_go = qry_q;
				num_v = (leaf_q == KW_ESE) ? ese_q : sre_q;
				ex_err = !qry_q && val_big;
				ex_code = `RCI_ERR_RANGE;
			end
			KW_ESR, KW_STB:
			begin
				ex_err = !qry_q;
				num_go = qry_q;
				num_v = (leaf_q == KW_ESR) ? esr_q : stb_now;
			end
			KW_IDN:
			begin
				ex_err = !qry_q;
				idn_go = qry_q;
			end
			KW_OPC: num_go = qry_q;
			KW_TST:
			begin
				ex_err = !qry_q;
				num_go = qry_q;
			end
			KW_RST:
			begin
				ex_err = qry_q;
				init_go = !qry_q;
			end
			KW_TRG, KW_WAI: ex_err = qry_q;
			KW_RCL:
			begin
				ex_err = qry_q || val_q == 16'h0000
					|| val_q > 16'(SLOTS);
				ex_code = qry_q ? `RCI_ERR_CMD : `RCI_ERR_RANGE;
				rcl_go = !ex_err;
			end
			KW_NONE: ;
			default:
			begin
				if (leaf_q == KW_ERROR && path_q == KW_SYSTEM && qry_q)
				begin
					num_go = 1'b1;
					num_v = err_q;
					num_neg = (err_q != 8'h00);
				end
				else if (!qry_q && (leaf_q == KW_TRIGGER
					|| (path_q == KW_TRIGGER && leaf_q != KW_SLOPE)))
					trig_go = 1'b1;
				else if (!qry_q && leaf_q == KW_DELETE)
					init_go = 1'b1;
				else
					dev_go = 1'b1;
			end
		endcase
	end

	// -------------------------------------------------------------
	// answer text
	// -------------------------------------------------------------
	logic [RB-1:0] rsp_str;
	logic [4:0] rsp_n;
	logic [7:0] dh, dt, d_o;
	always_comb
	begin
		dh = num_v / 8'h64;
		dt = (num_v / 8'h0a) % 8'h0a;
		d_o = num_v % 8'h0a;
		rsp_str = '0;
		rsp_n = 5'h00;
		if (idn_go)
		begin
			rsp_str = {IDN_STR, `RCI_CH_LF};
			rsp_n = 5'h10;
		end
		else if (num_go)
		begin
			if (num_neg)
			begin
				rsp_str = {rsp_str[RB-9:0], `RCI_CH_MINUS};
				rsp_n = rsp_n + 5'h01;
			end
			if (dh != 8'h00)
			begin
				rsp_str = {rsp_str[RB-9:0], dh + `RCI_CH_ZERO};
				rsp_n = rsp_n + 5'h01;
			end
			if (dh != 8'h00 || dt != 8'h00)
			begin
				rsp_str = {rsp_str[RB-9:0], dt + `RCI_CH_ZERO};
				rsp_n = rsp_n + 5'h01;
			end
			rsp_str = {rsp_str[RB-17:0], d_o + `RCI_CH_ZERO, `RCI_CH_LF};
			rsp_n = rsp_n + 5'h02;
			rsp_str = rsp_str << {(5'h10 - rsp_n), 3'h0};
		end
	end

	// -------------------------------------------------------------
	// status
	// -------------------------------------------------------------
	wire ex_fire = (state_q == S_EXEC);
	wire ch_fire = (state_q == S_CHAR);
	wire err_any = (ch_fire && pe_err) || (ex_fire && ex_err);
	wire [7:0] err_new = (ch_fire && pe_err) ? pe_code : ex_code;
	wire esr_clr = ex_fire && !ex_err && !qry_q && leaf_q == KW_CLS;
	wire esr_rdc = ex_fire && leaf_q == KW_ESR && qry_q;
	wire err_rdc = ex_fire && num_go && num_neg;
	wire [7:0] esr_set = err_any ? (err_new == `RCI_ERR_RANGE
		? 8'(1 << `RCI_ESR_EXE) : 8'(1 << `RCI_ESR_CME)) : 8'h00;
	wire [5:0] stb_low = {(esr_q & ese_q) != 8'h00, state_q == S_SEND,
		1'b0, err_q != 8'h00, 2'b00};
	assign stb_now = {1'b0, |(stb_low & sre_q[5:0]), stb_low};

	// event register; a set in the clearing cycle wins
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			esr_q <= `RCI_MASK_RESET;
		else
			esr_q <= (esr_q & ~{8{esr_clr || esr_rdc}}) | esr_set;
	end

	// masks and error record
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			ese_q <= `RCI_MASK_RESET;
			sre_q <= `RCI_MASK_RESET;
			err_q <= 8'h00;
		end
		else
		begin
			if (ex_fire && !ex_err && !qry_q && leaf_q == KW_ESE)
				ese_q <= val_q[7:0];
			if (ex_fire && !ex_err && !qry_q && leaf_q == KW_SRE)
				sre_q <= val_q[7:0];
			if (err_any)
				err_q <= err_new;
			else if (err_rdc)
				err_q <= 8'h00;
		end
	end

	// -------------------------------------------------------------
	// sequencer
	// -------------------------------------------------------------
	wire rd_next = ch_fire && !pe_err && !is_term;
	wire cmd_done = (ex_fire && !ex_err && rsp_n == 5'h00)
		|| (state_q == S_SEND && TX_READY && resp_n_q == 5'h01);
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			state_q <= S_LOAD;
			wr_q <= '0;
			rd_q <= '0;
			last_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				S_LOAD:
					if (rx_take)
					begin
						wr_q <= wr_q + 1'b1;
						if (RX_DATA == `RCI_CH_LF
							|| wr_q == CW'(DEPTH - 1))
							state_q <= S_READ;
					end
				S_READ: state_q <= S_CHAR;
				S_CHAR:
				begin
					last_q <= is_lf;
					if (pe_err)
						state_q <= S_CLEAR;
					else if (is_term)
						state_q <= S_EXEC;
					else
					begin
						rd_q <= rd_q + 1'b1;
						state_q <= S_READ;
					end
				end
				S_EXEC, S_SEND:
					if (ex_fire && ex_err)
						state_q <= S_CLEAR;
					else if (ex_fire && rsp_n != 5'h00)
						state_q <= S_SEND;
					else if (cmd_done)
					begin
						rd_q <= rd_q + 1'b1;
						state_q <= last_q ? S_CLEAR : S_READ;
					end
				S_CLEAR:
				begin
					wr_q <= '0;
					rd_q <= '0;
					state_q <= S_LOAD;
				end
			endcase
		end
	end

	// -------------------------------------------------------------
	// header parser
	// -------------------------------------------------------------
	wire cmd_reset = cmd_done || state_q == S_CLEAR;
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			tok_q <= '0;
			tok_n_q <= 4'h0;
			{star_q, hdr_q, qry_q, has_val_q} <= 4'h0;
			first_q <= 1'b1;
			val_q <= 16'h0000;
			leaf_q <= KW_NONE;
			path_q <= KW_NONE;
		end
		else if (cmd_reset)
		begin
			tok_q <= '0;
			tok_n_q <= 4'h0;
			{star_q, hdr_q, qry_q, has_val_q} <= 4'h0;
			first_q <= 1'b1;
			val_q <= 16'h0000;
			leaf_q <= KW_NONE;
			// semicolon keeps path, new batch roots
			if (state_q == S_CLEAR)
				path_q <= KW_NONE;
		end
		else if (ch_fire && !pe_err && !hdr_q)
		begin
			if (is_alpha)
			begin
				tok_q <= {tok_q[TB-9:0], ch_up};
				tok_n_q <= tok_n_q + 4'h1;
				first_q <= 1'b0;
			end
			else if (ch == `RCI_CH_STAR)
				star_q <= 1'b1;
			else if (ch == `RCI_CH_COLON)
			begin
				path_q <= (tok_n_q == 4'h0) ? KW_NONE : kw_id;
				tok_q <= '0;
				tok_n_q <= 4'h0;
				first_q <= 1'b0;
			end
			else if (tok_n_q != 4'h0)
			begin
				leaf_q <= kw_id;
				hdr_q <= 1'b1;
				qry_q <= (ch == `RCI_CH_QUERY);
			end
		end
		else if (ch_fire && hdr_q && is_digit)
		begin
			val_q <= val_nx;
			has_val_q <= 1'b1;
		end
	end

	// -------------------------------------------------------------
	// answer sender
	// -------------------------------------------------------------
	assign TX_VALID = (state_q == S_SEND);
	assign TX_DATA = resp_q[RB-1:RB-8];
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			resp_q <= '0;
			resp_n_q <= 5'h00;
		end
		else if (ex_fire)
		begin
			resp_q <= rsp_str;
			resp_n_q <= rsp_n;
		end
		else if (TX_VALID && TX_READY)
		begin
			resp_q <= {resp_q[RB-9:0], 8'h00};
			resp_n_q <= resp_n_q - 5'h01;
		end
	end

	// -------------------------------------------------------------
	// outputs to the settings engine
	// -------------------------------------------------------------
	wire ex_ok = ex_fire && !ex_err;
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			CMD <= '{KW_NONE, KW_NONE, 1'b0, 16'h0000};
			{CMD_VALID, TRIG_PULSE, INIT_PULSE, RECALL_PULSE} <= 4'h0;
			RECALL_SLOT <= 5'h00;
			ERR_PULSE <= 1'b0;
			ERR_CODE <= 8'h00;
			STATUS_BYTE <= 8'h00;
			EVENT_STATUS <= 8'h00;
		end
		else
		begin
			if (ex_ok && dev_go)
				CMD <= '{path_q, leaf_q, qry_q, val_q};
			CMD_VALID <= ex_ok && dev_go;
			TRIG_PULSE <= ex_ok && trig_go;
			INIT_PULSE <= ex_ok && init_go;
			RECALL_PULSE <= ex_ok && rcl_go;
			if (ex_ok && rcl_go)
				RECALL_SLOT <= val_q[4:0];
			ERR_PULSE <= err_any;
			if (err_any)
				ERR_CODE <= err_new;
			STATUS_BYTE <= stb_now;
			EVENT_STATUS <= esr_q;
		end
	end

endmodule

// ==== rci_top_checker.sv ====
/* port assertions of the command interpreter top.
 * assumes one clock MCLK and asynchronous active-high RST. */
`timescale 1ns/1ps

module rci_top_checker
	import rci_pkg::*;
#(
	parameter int SLOTS = 20
)
(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [7:0] RX_DATA,
	input wire logic RX_VALID,
	input wire logic RX_READY,
	input wire logic [7:0] TX_DATA,
	input wire logic TX_VALID,
	input wire logic TX_READY,
	input wire logic CMD_VALID,
	input wire logic RECALL_PULSE,
	input wire logic [4:0] RECALL_SLOT,
	input wire logic ERR_PULSE,
	input wire logic [7:0] ERR_CODE,
	input wire logic [7:0] STATUS_BYTE,
	input wire logic [7:0] EVENT_STATUS
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);

	// batch closed by its line end
	sequence lf_taken;
		RX_VALID && RX_READY && RX_DATA == 8'h0a;
	endsequence

	// error pulse carrying a given code
	sequence err_of(logic [7:0] code);
		ERR_PULSE && ERR_CODE == code;
	endsequence

	a_opc_never_set: assert property (!EVENT_STATUS[0])
		else $error("operation complete bit set");
	a_hdr_err_event: assert property (
		err_of(8'h71) |-> ##[1:3] EVENT_STATUS[5])
		else $error("header error not in event status");
	a_rng_err_event: assert property (
		err_of(8'hde) |-> ##[1:3] EVENT_STATUS[4])
		else $error("range error not in event status");
	a_err_record: assert property (
		ERR_PULSE |-> ##[1:3] STATUS_BYTE[2])
		else $error("error record bit missing");
	a_skip_after_err: assert property (
		ERR_PULSE |=> !CMD_VALID [*8])
		else $error("command executed after error");
	a_tx_holds: assert property (
		TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
		else $error("answer byte changed while stalled");
	a_tx_blocks_rx: assert property (TX_VALID |-> !RX_READY)
		else $error("input open while answering");
	a_lf_closes: assert property (lf_taken |=> !RX_READY [*4])
		else $error("input not closed after line end");
	a_summary_bit: assert property (
		STATUS_BYTE[6] |-> STATUS_BYTE[5:0] != 6'h00)
		else $error("summary bit without cause");
	a_recall_slot: assert property (
		RECALL_PULSE |-> RECALL_SLOT >= 5'h01 && RECALL_SLOT <= SLOTS)
		else $error("recall of invalid slot");
endmodule

bind rci_top rci_top_checker #(.SLOTS(SLOTS)) rci_top_checker_i (
	.MCLK(MCLK), .RST(RST), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
	.RX_READY(RX_READY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
	.TX_READY(TX_READY), .CMD_VALID(CMD_VALID),
	.RECALL_PULSE(RECALL_PULSE), .RECALL_SLOT(RECALL_SLOT),
	.ERR_PULSE(ERR_PULSE), .ERR_CODE(ERR_CODE),
	.STATUS_BYTE(STATUS_BYTE), .EVENT_STATUS(EVENT_STATUS));

// ==== rci_host.sv ====
/* host model: sends command batches byte by byte, drains answers.
 * assumes one clock; the bench calls send and reads ans. */
`timescale 1ns/1ps

module rci_host
(
	input wire logic mclk,
	input wire logic slow,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready
);
	byte unsigned ans[$];
	logic [1:0] ph = 2'h0;

	initial
	begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end

	// drain answers, only every fourth cycle when slow
	always @(posedge mclk)
	begin
		ph <= ph + 2'h1;
		tx_ready <= !slow || ph == 2'h0;
		if (tx_valid && tx_ready)
			ans.push_back(tx_data);
	end

	task automatic send(input string s);
		for (int k = 0; k < s.len(); k++)
		begin
			rx_data <= s[k];
			rx_valid <= 1'b1;
			@(negedge mclk);
			while (!rx_ready)
				@(negedge mclk);
			@(posedge mclk);
		end
		rx_valid <= 1'b0;
		rx_data <= ~rx_data; // released line shows no stale byte
	endtask
endmodule

// ==== rci_top_test.sv ====
/* self-checking bench: batches with expected answers, then counts and
 * a mid-run reset. assumes rci_top, rci_host and the checker. */
`timescale 1ns/1ps

module rci_top_test;
	logic MCLK = 1'b0;
	logic RST = 1'b1;
	logic slow = 1'b0;
	logic [7:0] rx_data, tx_data, status_byte, event_status;
	logic rx_valid, rx_ready, tx_valid, tx_ready;
	logic init_pulse, recall_pulse, trig_pulse;
	logic [4:0] recall_slot;
	logic cmd_valid;
	rci_pkg::rci_cmd_t cmd;
	int mismatches = 0;
	int num_checks = 0;
	int n_init = 0;
	int n_rcl = 0;
	int n_trig = 0;
	int n_cmd = 0;
	typedef struct {string cmd; string ans; logic [7:0] stb;} rci_row_t;
	rci_row_t rows [13] = '{
		'{"*ESE 36;*ESE?\n", "36\n", 8'h00},
		'{"*SRE 32;*SRE?\n", "32\n", 8'h00},
		'{"*OPC;*OPC?;*TST?\n", "0\n0\n", 8'h00},
		'{"*TRG;*WAI;:SYST:ERR?\n", "0\n", 8'h00},
		'{"SOURCE:freq 5;:SYST:ERR?\n", "0\n", 8'h00},
		'{"*IDN?\n", "TSTCO,FG,000,09\n", 8'h00},
		'{"SOURC:FREQ 5;*TST?\n", "", 8'h64},
		'{"*STB?;*ESR?;:SYST:ERR?\n", "100\n32\n-113\n", 8'h00},
		'{"*ESE 1;*ESE 2;*ESE 3;*OPC;;*ESE?", "3\n", 8'h00},
		'{"*RCL 21\n", "", 8'h04},
		'{"*CLS;*ESR?;:SYST:ERR?\n", "0\n-222\n", 8'h00},
		'{"*RST;MEM:STAT:DEL;*RCL 7\n", "", 8'h00},
		'{":TRIG;*CLS?\n", "", 8'h04}
	};

	always #5 MCLK = ~MCLK;

	rci_top #(.DEPTH(32), .SLOTS(20), .IDN_STR("TSTCO,FG,000,09")) rci_top_i (
		.MCLK(MCLK), .RST(RST), .RX_DATA(rx_data), .RX_VALID(rx_valid),
		.RX_READY(rx_ready), .TX_DATA(tx_data), .TX_VALID(tx_valid),
		.TX_READY(tx_ready), .CMD(cmd), .CMD_VALID(cmd_valid),
		.TRIG_PULSE(trig_pulse), .INIT_PULSE(init_pulse),
		.RECALL_PULSE(recall_pulse),
		.RECALL_SLOT(recall_slot), .ERR_PULSE(), .ERR_CODE(),
		.STATUS_BYTE(status_byte), .EVENT_STATUS(event_status));
	rci_host rci_host_i (.mclk(MCLK), .slow(slow), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready));

	// count pulses towards the settings side
	always @(posedge MCLK)
	begin
		n_init <= n_init + int'(init_pulse);
		n_rcl <= n_rcl + int'(recall_pulse);
		n_trig <= n_trig + int'(trig_pulse);
		n_cmd <= n_cmd + int'(cmd_valid);
	end

	task automatic check_cmd(input rci_pkg::rci_cmd_t got,
		input rci_pkg::rci_cmd_t exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t command %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_str(input string got, input string exp);
		num_checks++;
		if (got != exp)
		begin
			mismatches++;
			$display("[ERR] %0t answer text differs", $time);
		end
	endtask

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// send one batch, wait for the input to reopen, collect answers
	task automatic run(input string cmd, input logic s, output string got);
		int n;
		@(posedge MCLK);
		slow <= s;
		rci_host_i.ans.delete();
		rci_host_i.send(cmd);
		n = 0;
		@(negedge MCLK);
		while (!rx_ready && n < 3000)
		begin
			@(negedge MCLK);
			n++;
		end
		if (n >= 3000)
		begin
			mismatches++;
			$display("[ERR] %0t batch never finished", $time);
		end
		got = "";
		foreach (rci_host_i.ans[k])
			got = {got, string'(rci_host_i.ans[k])};
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// main sequence: table rows, then pulse counts and a reset
	initial
	begin
		string got;
		rci_pkg::rci_cmd_t cmd_exp;
		repeat (16) @(posedge MCLK);
		RST <= 1'b0;
		foreach (rows[i])
		begin
			run(rows[i].cmd, i[0], got);
			check_str(got, rows[i].ans);
			check_byte(status_byte, rows[i].stb);
			$display("row %0d done", i);
		end
		check_byte({3'h0, recall_slot}, 8'h07);
		check_byte(8'(n_rcl), 8'h01);
		check_byte(8'(n_init), 8'h02);
		check_byte(8'(n_trig), 8'h01);
		check_byte(8'(n_cmd), 8'h01);
		cmd_exp = '{rci_pkg::KW_SOURCE, rci_pkg::KW_FREQUENCY, 1'b0,
			16'h0005};
		check_cmd(cmd, cmd_exp);
		$display("pulse counts done");
		@(posedge MCLK);
		RST <= 1'b1;
		repeat (16) @(posedge MCLK);
		RST <= 1'b0;
		@(negedge MCLK);
		check_byte({7'h00, rx_ready}, 8'h01);
		check_byte(event_status | status_byte, 8'h00);
		run("*ESE?\n", 1'b0, got);
		check_str(got, "0\n");
		$display("mid-run reset done");
		report_and_stop();
	end

	// cut a hang short; all batches need well under this
	initial
	begin
		repeat (60000) @(posedge MCLK);
		mismatches++;
		report_and_stop();
	end
endmodule
